// ---- rtl/eqr_pkg.sv ----
// Package for the queue 1 egress rate-limit block: map, fields, types.
package eqr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          EQR_NPORT     = 3;        // Ports 2, 3 and 4
    localparam int          EQR_ADDR_W    = 8;        // Register address
    localparam int          EQR_DATA_W    = 8;        // Register data
    localparam logic [7:0]  EQR_OFS_P2    = 8'hdc;    // Port 2 queue 1 limit
    localparam logic [7:0]  EQR_OFS_P3    = 8'hec;    // Port 3 queue 1 limit
    localparam logic [7:0]  EQR_OFS_P4    = 8'hfc;    // Port 4 queue 1 limit

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          EQR_RATE_LSB  = 0;        // Rate field low bit
    localparam int          EQR_RATE_W    = 7;        // Rate field bits 6..0
    localparam logic [6:0]  EQR_RATE_RST  = 7'h00;    // Rate field reset
    localparam logic [6:0]  EQR_RATE_FULL = 7'h64;    // 100: full rate
    localparam logic [1:0]  EQR_PRIO_Q1   = 2'h1;     // Priority shaped here

    // ------------------------------------------------------------------
    // Timing: one credit tick per microsecond, so 1 Mbps is 1 bit/tick
    // ------------------------------------------------------------------
    localparam int          EQR_CLK_NS    = 10;       // Core clock period
    localparam int          EQR_TICK_NS   = 1000;     // Credit tick period
    localparam int          EQR_TICK_CYC  = EQR_TICK_NS / EQR_CLK_NS;

    // ------------------------------------------------------------------
    // Shaper sizing
    // ------------------------------------------------------------------
    localparam int          EQR_LEN_W     = 11;       // Frame length, bytes
    localparam int          EQR_CRED_W    = 18;       // Signed credit, bits
    localparam logic [17:0] EQR_BURST     = 18'h0_4000; // Credit cap, bits

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Queue count a port runs with
    typedef enum logic [1:0] {
        EQR_QM_ONE,
        EQR_QM_TWO,
        EQR_QM_FOUR
    } eqr_qmode_t;

    // Rank of queue 1 among the port's queues
    typedef enum logic [1:0] {
        EQR_RANK_NONE,
        EQR_RANK_HIGH,
        EQR_RANK_MID
    } eqr_rank_t;

    // Egress frame offered by the scheduler
    typedef struct packed {
        logic                 valid;  // Frame waiting
        logic [1:0]           prio;   // Frame priority
        logic [EQR_LEN_W-1:0] len;    // Frame length in bytes
    } eqr_req_t;

endpackage : eqr_pkg

// ---- rtl/eqr_shaper.sv ----
// Credit shaper for the queue 1 egress traffic of one port.
`timescale 1ns/1ps
`default_nettype none
module eqr_shaper
(
    input  wire logic                  mclk_i,   // Core clock
    input  wire logic                  arst_n_i, // Async reset, active low
    input  wire logic                  tick_i,   // One pulse per microsecond
    input  wire logic [6:0]            rate_i,   // Programmed rate field
    input  wire logic                  exact_i,  // Queue 1 held to exact rate
    input  wire eqr_pkg::eqr_req_t     req_i,    // Offered frame
    output logic                       grant_o   // One-cycle release pulse
);
    import eqr_pkg::*;

    // ------------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------------
    logic signed [EQR_CRED_W-1:0] credit_r;    // Bits that may leave now
    logic signed [EQR_CRED_W-1:0] credit_nxt;  // Next credit value
    logic                         shaped;      // This frame is rate held
    logic                         limited;     // Field picks below full rate
    logic                         take;        // Release the frame now
    logic                         grant_r;     // Registered release

    // Values 0 and 100 mean full rate; 1..99 are Mbps
    assign limited = (rate_i != EQR_RATE_RST)
                     && (rate_i < EQR_RATE_FULL);
    // Only priority 1 frames on the exact-rate queue are held
    assign shaped  = exact_i && limited
                     && (req_i.prio == EQR_PRIO_Q1);
    // Deficit credit lets a whole frame go once credit is non-negative;
    // the debt repaid later keeps the long-run rate exact
    assign take    = req_i.valid && !grant_r
                     && (!shaped || (credit_r >= 0));

    // ------------------------------------------------------------------
    // Credit arithmetic
    // ------------------------------------------------------------------
    // Adds the rate each tick, charges eight bits per shaped byte
    always_comb
    begin
        credit_nxt = credit_r;
        if (!(exact_i && limited))
        begin
            // Unlimited: park at the cap so limiting starts with a burst
            credit_nxt = $signed(EQR_BURST);
        end
        else
        begin
            if (tick_i)
            begin
                credit_nxt = credit_nxt
                    + $signed({{(EQR_CRED_W-EQR_RATE_W){1'b0}}, rate_i});
            end
            if (take && shaped)
            begin
                credit_nxt = credit_nxt
                    - $signed({{(EQR_CRED_W-EQR_LEN_W-3){1'b0}},
                               req_i.len, 3'b000});
            end
            if (credit_nxt > $signed(EQR_BURST))
            begin
                // Cap idle savings so bursts stay bounded
                credit_nxt = $signed(EQR_BURST);
            end
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Credit register
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            credit_r <= $signed(EQR_BURST);
        else
            credit_r <= credit_nxt;
    end

    // Grant pulse; blocks a grant in the cycle right after each grant
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            grant_r <= 1'b0;
        else
            grant_r <= take;
    end

    assign grant_o = grant_r;

endmodule : eqr_shaper
`default_nettype wire

// ---- rtl/eqr_top.sv ----
// Queue 1 egress rate-limit registers and shapers for ports 2 to 4.
//
// Contract
// - Seven-bit R/W rate field, bits 6..0, reset zero
// - Limit applies only to priority 1 egress frames
// - Shape queue traffic to selected rate encoding
// - Four queues: queue 1 is mid priority
// - Two queues: queue 1 is high priority
// - 1..99 Mbps; 0 or 100 full rate
// - Exact rate only on highest queue; ratio otherwise
`timescale 1ns/1ps
`default_nettype none
module eqr_top
#(
    parameter int TICK_CYC = eqr_pkg::EQR_TICK_CYC   // Cycles per credit tick
)
(
    input  wire logic                          mclk_i,     // Core clock
    input  wire logic                          arst_n_i,   // Async reset
    // Register port
    input  wire logic [7:0]                    reg_addr_i, // Byte address
    input  wire logic                          reg_wr_i,   // Write strobe
    input  wire logic [7:0]                    reg_wdata_i,// Write data
    input  wire logic                          reg_rd_i,   // Read strobe
    output logic      [7:0]                    reg_rdata_o,// Read data
    output logic                               reg_rvld_o, // Read data valid
    // Per-port queue mode, index 0 is port 2
    input  wire eqr_pkg::eqr_qmode_t [2:0]     qmode_i,    // Queues in use
    // Scheduler side
    input  wire eqr_pkg::eqr_req_t   [2:0]     req_i,      // Offered frames
    output logic      [2:0]                    grant_o,    // Release pulses
    output eqr_pkg::eqr_rank_t       [2:0]     rank_o,     // Queue 1 rank
    output logic      [2:0]                    ratio_o,    // Queue 1 by ratio
    output logic      [2:0][6:0]               rate_o      // Active rate field
);
    import eqr_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // A zero-length tick cannot be counted
    if (TICK_CYC < 1)
    begin : g_bad_tick
        $error("eqr_top: TICK_CYC must be at least one");
    end

    // Address of each port's register, index 0 is port 2
    localparam logic [2:0][7:0] OFS = {EQR_OFS_P4, EQR_OFS_P3, EQR_OFS_P2};
    localparam int              TCW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0][6:0]  rate_r;     // Stored rate fields
    logic [7:0]       rdata_r;    // Read data register
    logic             rvld_r;     // Read answer strobe
    logic [TCW-1:0]   tcnt_r;     // Tick divider count
    logic             tick_r;     // One-cycle microsecond enable
    logic [2:0]       exact_r;    // Queue 1 is the port's top queue
    eqr_rank_t [2:0]  rank_r;     // Rank of queue 1 per port
    logic [2:0]       ratio_r;    // Queue 1 follows the ratio control
    logic [2:0]       hit;        // Address decode per port
    logic [2:0]       grant;      // Shaper grants, already registered

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // One match line per register
    always_comb
    begin
        for (int p = 0; p < EQR_NPORT; p++)
        begin
            hit[p] = (reg_addr_i == OFS[p]);
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Only bits 6..0 are stored; bit 7 has no flop, so writes to it vanish
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int p = 0; p < EQR_NPORT; p++)
            begin
                rate_r[p] <= EQR_RATE_RST;
            end
        end
        else if (reg_wr_i)
        begin
            for (int p = 0; p < EQR_NPORT; p++)
            begin
                if (hit[p])
                begin
                    // Low seven bits only
                    rate_r[p] <=
                        reg_wdata_i[EQR_RATE_LSB +: EQR_RATE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_r <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            rdata_r <= 8'h00;
            for (int p = 0; p < EQR_NPORT; p++)
            begin
                if (hit[p])
                begin
                    // Reserved top bit always reads zero
                    rdata_r <= {1'b0, rate_r[p]};
                end
            end
        end
    end

    // Read answer strobe
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rvld_r <= 1'b0;
        else
            rvld_r <= reg_rd_i;
    end

    // ------------------------------------------------------------------
    // Microsecond enable
    // ------------------------------------------------------------------
    // Free-running divider; one tick adds rate bits, so Mbps maps exactly
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tcnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (tcnt_r == TCW'(TICK_CYC - 1))
        begin
            tcnt_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            tcnt_r <= tcnt_r + TCW'(1);
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Queue ranking
    // ------------------------------------------------------------------
    // Rank follows the port's queue count; registered, so a mode change
    // reaches the shaper one cycle later, harmless for a static setting
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int p = 0; p < EQR_NPORT; p++)
            begin
                rank_r[p]  <= EQR_RANK_NONE;
                exact_r[p] <= 1'b0;
                ratio_r[p] <= 1'b0;
            end
        end
        else
        begin
            for (int p = 0; p < EQR_NPORT; p++)
            begin
                case (qmode_i[p])
                    EQR_QM_TWO:
                    begin
                        // Queue 1 is the high queue, held to exact rate
                        rank_r[p]  <= EQR_RANK_HIGH;
                        exact_r[p] <= 1'b1;
                        ratio_r[p] <= 1'b0;
                    end
                    EQR_QM_FOUR:
                    begin
                        // Queue 3 is on top; queue 1 yields to the ratio
                        rank_r[p]  <= EQR_RANK_MID;
                        exact_r[p] <= 1'b0;
                        ratio_r[p] <= 1'b1;
                    end
                    default:
                    begin
                        // Single queue: queue 1 carries no traffic
                        rank_r[p]  <= EQR_RANK_NONE;
                        exact_r[p] <= 1'b0;
                        ratio_r[p] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-port shapers
    // ------------------------------------------------------------------
    for (genvar p = 0; p < EQR_NPORT; p++)
    begin : g_port
        eqr_shaper u_shaper
        (
            .mclk_i   (mclk_i),
            .arst_n_i (arst_n_i),
            .tick_i   (tick_r),
            .rate_i   (rate_r[p]),
            .exact_i  (exact_r[p]),
            .req_i    (req_i[p]),
            .grant_o  (grant[p])
        );
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign reg_rdata_o = rdata_r;
    assign reg_rvld_o  = rvld_r;
    assign grant_o     = grant;
    assign rank_o      = rank_r;
    assign ratio_o     = ratio_r;
    assign rate_o      = rate_r;

endmodule : eqr_top
`default_nettype wire

// ---- tb/eqr_top_assertions.sv ----
// Port checker for the queue 1 egress rate-limit block.
`timescale 1ns/1ps
`default_nettype none
module eqr_top_assertions
#(
    parameter int TICK_CYC = 100                   // Cycles per credit tick
)
(
    input  wire logic                      mclk_i,      // Core clock
    input  wire logic                      arst_n_i,    // Async reset
    input  wire logic [7:0]                reg_addr_i,  // Byte address
    input  wire logic                      reg_wr_i,    // Write strobe
    input  wire logic [7:0]                reg_wdata_i, // Write data
    input  wire logic                      reg_rd_i,    // Read strobe
    input  wire logic [7:0]                reg_rdata_o, // Read data
    input  wire logic                      reg_rvld_o,  // Read valid
    input  wire eqr_pkg::eqr_qmode_t [2:0] qmode_i,     // Queues in use
    input  wire eqr_pkg::eqr_req_t   [2:0] req_i,       // Offered frames
    input  wire logic [2:0]                grant_o,     // Release pulses
    input  wire eqr_pkg::eqr_rank_t  [2:0] rank_o,      // Queue 1 rank
    input  wire logic [2:0]                ratio_o,     // Ratio control
    input  wire logic [2:0][6:0]           rate_o       // Stored rates
);
    import eqr_pkg::*;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic mapped;                                  // Address hits the map
    assign mapped = (reg_addr_i == EQR_OFS_P2) || (reg_addr_i == EQR_OFS_P3)
                 || (reg_addr_i == EQR_OFS_P4);
    // Reset disables every check so no stale history fires
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_rvld_after_rd: assert property (reg_rd_i |=> reg_rvld_o)
        else $error("read valid missing after read strobe");
    a_rvld_only_rd: assert property (reg_rvld_o |-> $past(reg_rd_i))
        else $error("read valid without read strobe");
    a_read_port4: assert property (reg_rd_i
        && reg_addr_i == EQR_OFS_P4
        |=> reg_rdata_o == {1'b0, $past(rate_o[2])})
        else $error("port 4 read data wrong");
    a_read_unmapped: assert property (reg_rd_i && !mapped
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_write_port2: assert property (reg_wr_i
        && reg_addr_i == EQR_OFS_P2
        |=> rate_o[0] == $past(reg_wdata_i[6:0]))
        else $error("port 2 write not stored");
    a_rate_hold: assert property (!reg_wr_i |=> $stable(rate_o))
        else $error("rate changed without write");
    a_rank_two: assert property (qmode_i[0] == EQR_QM_TWO
        |=> rank_o[0] == EQR_RANK_HIGH && !ratio_o[0])
        else $error("two queue rank wrong");
    a_rank_four: assert property (qmode_i[2] == EQR_QM_FOUR
        |=> rank_o[2] == EQR_RANK_MID && ratio_o[2])
        else $error("four queue rank wrong");
    a_grant_gap: assert property (grant_o[1] |=> !grant_o[1])
        else $error("grant pulses back to back");
    a_unshaped_grant: assert property (req_i[0].valid &&
        req_i[0].prio != EQR_PRIO_Q1 && !grant_o[0] |=> grant_o[0])
        else $error("other priority frame delayed");
    // Main scenarios reached
    cover property (reg_rd_i && !mapped);
    cover property (req_i[0].valid && !grant_o[0] [*8]);
    cover property (ratio_o[2] && grant_o[2]);
endmodule : eqr_top_assertions
bind eqr_top eqr_top_assertions #(.TICK_CYC(TICK_CYC)) chk_u (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvld_o(reg_rvld_o), .qmode_i(qmode_i),
    .req_i(req_i), .grant_o(grant_o), .rank_o(rank_o), .ratio_o(ratio_o),
    .rate_o(rate_o));
`default_nettype wire

// ---- tb/tb_eqr_top.sv ----
// Self-checking bench for the queue 1 egress rate-limit block.
`timescale 1ns/1ps
`default_nettype none
module tb_eqr_top;
    import eqr_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus table and signals
    // ------------------------------------------------------------------
    localparam int TCYC = 4;                       // Short tick keeps run fast
    typedef struct packed {
        logic [7:0] addr;                          // Register address
        logic [7:0] wdata;                         // Value written
        logic [7:0] expv;                          // Value read back
        logic [1:0] port;                          // Port index, 3 is none
    } eqr_row_t;
    localparam eqr_row_t ROWS [5] = '{
        '{8'hdc, 8'h8a, 8'h0a, 2'h0}, '{8'hec, 8'h7f, 8'h7f, 2'h1},
        '{8'hfc, 8'he4, 8'h64, 2'h2}, '{8'hcc, 8'h55, 8'h00, 2'h3},
        '{8'hdd, 8'h33, 8'h00, 2'h3}};
    logic                 mclk_i;                  // Core clock
    logic                 arst_n_i;                // Async reset
    logic [7:0]           reg_addr_i, reg_wdata_i; // Register address, data
    logic                 reg_wr_i, reg_rd_i;      // Register strobes
    logic [7:0]           reg_rdata_o;             // Read data
    logic                 reg_rvld_o;              // Read valid
    eqr_qmode_t [2:0]     qmode_i;                 // Queue modes
    eqr_req_t   [2:0]     req_i;                   // Offered frames
    logic [2:0]           grant_o, ratio_o;        // Grants, ratio flags
    eqr_rank_t  [2:0]     rank_o;                  // Ranks
    logic [2:0][6:0]      rate_o;                  // Stored rates
    int                   miscompares, compares, cycles, n;
    logic [7:0]           rv;                      // Read result
    eqr_top #(.TICK_CYC(TCYC)) dut_u (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvld_o(reg_rvld_o),
        .qmode_i(qmode_i), .req_i(req_i), .grant_o(grant_o),
        .rank_o(rank_o), .ratio_o(ratio_o), .rate_o(rate_o));
    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    always #5 mclk_i = ~mclk_i;
    // Whole run needs about 3100 cycles; a hang ends it here
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        compares++;
        if (e !== g)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Strobes last one cycle; data is driven just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i); #1;
        reg_wr_i = 1'b1; reg_addr_i = a; reg_wdata_i = d;
        @(posedge mclk_i); #1;
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i); #1;
        reg_rd_i = 1'b1; reg_addr_i = a;
        @(posedge mclk_i); #1;
        reg_rd_i = 1'b0;
        chk("rvld", 8'h01, {7'h00, reg_rvld_o});
        d = reg_rdata_o;
    endtask : rd
    // Offers one frame and counts cycles until its grant is seen
    task automatic send(input int p, input logic [1:0] pr,
                        input logic [10:0] ln, input int lim, output int k);
        @(posedge mclk_i); #1;
        req_i[p] = {1'b1, pr, ln};
        k = 0;
        while (k < lim && grant_o[p] !== 1'b1)
        begin
            @(posedge mclk_i); #1;
            k++;
        end
        req_i[p].valid = 1'b0;
    endtask : send
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk_i = 0; arst_n_i = 0; reg_addr_i = 0; reg_wdata_i = 0;
        reg_wr_i = 0; reg_rd_i = 0; qmode_i = {3{EQR_QM_ONE}}; req_i = '0;
        miscompares = 0; compares = 0; cycles = 0;
        repeat (5) @(posedge mclk_i);
        chk("rate_rst", 8'h00,
            {1'b0, rate_o[0] | rate_o[1] | rate_o[2]});
        chk("rank_rst", 8'h00, {2'h0, rank_o});
        #1 arst_n_i = 1;
        for (int i = 0; i < 3; i++)
        begin
            rd(ROWS[i].addr, rv);
            chk("reset_read", 8'h00, rv);
        end
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, rv);
            chk("readback", ROWS[i].expv, rv);
            if (ROWS[i].port != 2'h3)
                chk("rate_o", ROWS[i].expv,
                    {1'b0, rate_o[ROWS[i].port]});
        end
        for (int i = 0; i < 3; i++)
        begin
            rd(ROWS[i].addr, rv);
            chk("kept", ROWS[i].expv, rv);
        end
        $display("test registers done");
        qmode_i = {3{EQR_QM_TWO}};
        repeat (2) @(posedge mclk_i); #1;
        chk("rank_two", {2'h0, {3{EQR_RANK_HIGH}}}, {2'h0, rank_o});
        chk("ratio_two", 8'h00, {5'h00, ratio_o});
        qmode_i = {3{EQR_QM_FOUR}};
        repeat (2) @(posedge mclk_i); #1;
        chk("rank_four", {2'h0, {3{EQR_RANK_MID}}}, {2'h0, rank_o});
        chk("ratio_four", 8'h07, {5'h00, ratio_o});
        $display("test modes done");
        wr(8'hfc, 8'h0a);
        qmode_i = {EQR_QM_FOUR, EQR_QM_TWO, EQR_QM_TWO};
        // Port 3 runs 127, then 0, then 100: each must stay unthrottled
        for (int i = 0; i < 12; i++)
        begin
            if (i == 3)
                wr(8'hec, 8'h00);
            if (i == 6)
                wr(8'hec, 8'h64);
            send((i < 9) ? 1 : 2, 2'h1, 11'd1500, 50, n);
            chk("full_rate", 8'h01, n[7:0]);
        end
        send(0, 2'h1, 11'd1500, 50, n);
        chk("shaped_1", 8'h01, n[7:0]);
        send(0, 2'h1, 11'd1500, 50, n);
        chk("shaped_2", 8'h01, n[7:0]);
        send(0, 2'h0, 11'd1500, 50, n);
        chk("other_prio", 8'h01, n[7:0]);
        // Credit near -7600 bits refills at 10 bits per tick
        send(0, 2'h1, 11'd1500, 4000, n);
        chk("held", 8'h01, {7'h00, n >= 2900 && n <= 3200});
        $display("test shaping done");
        arst_n_i = 0;
        @(posedge mclk_i); #1;
        chk("mid_reset", 8'h00, {1'b0, rate_o[0]});
        arst_n_i = 1;
        rd(8'hdc, rv);
        chk("after_reset", 8'h00, rv);
        $display("test second reset done");
        stop_test();
    end
endmodule : tb_eqr_top
`default_nettype wire
